// ---- hw/sgdd_defs.svh ----
`ifndef SGDD_DEFS_SVH
`define SGDD_DEFS_SVH

// Register byte offsets
`define SGDD_OFS_DESC_LO 8'h00
`define SGDD_OFS_DESC_HI 8'h04
`define SGDD_OFS_CTRL 8'h08
`define SGDD_OFS_CMD 8'h0C
`define SGDD_OFS_STATUS 8'h10
`define SGDD_OFS_TARGET_SEL 8'h14
`define SGDD_OFS_TARGET_OFS 8'h18
`define SGDD_OFS_PARAM 8'h1C
`define SGDD_OFS_CODE_ATTR 8'h20
`define SGDD_OFS_HIDDEN_LO 8'h24
`define SGDD_OFS_HIDDEN_HI 8'h28
`define SGDD_STATE_PAGE 4'h4

// Descriptor upper-word fields
`define SGDD_BIT_CLASS 12
`define SGDD_BIT_LONG 21
`define SGDD_BIT_DSIZE 22

// System type codes
`define SGDD_T_RSV0 4'h0
`define SGDD_T_TASK16_AVL 4'h1
`define SGDD_T_LOCAL 4'h2
`define SGDD_T_TASK16_BUSY 4'h3
`define SGDD_T_CALL16 4'h4
`define SGDD_T_TASK_GATE 4'h5
`define SGDD_T_INT16 4'h6
`define SGDD_T_TRAP16 4'h7
`define SGDD_T_RSV8 4'h8
`define SGDD_T_TASK32_AVL 4'h9
`define SGDD_T_RSVA 4'hA
`define SGDD_T_TASK32_BUSY 4'hB
`define SGDD_T_CALL32 4'hC
`define SGDD_T_RSVD 4'hD
`define SGDD_T_INT32 4'hE
`define SGDD_T_TRAP32 4'hF

// Table source codes
`define SGDD_TBL_GLOBAL 2'h0
`define SGDD_TBL_LOCAL 2'h1
`define SGDD_TBL_VECTOR 2'h2

// Command bits, sizes, reset values, bus answers
`define SGDD_CMD_USE 0
`define SGDD_CMD_SUSPEND 1
`define SGDD_CMD_RESTART 2
`define SGDD_PBYTES_32 3'h4
`define SGDD_PBYTES_16 3'h2
`define SGDD_STATE_WORDS 4
`define SGDD_STATE_LAST 3'h3
`define SGDD_RST_WORD 32'h0000_0000
`define SGDD_RESP_OKAY 2'h0
`define SGDD_RESP_SLVERR 2'h2

`endif

// ---- hw/sgdd_pkg.sv ----
package sgdd_pkg;

  typedef enum logic [3:0] {
    KIND_ILLEGAL = 4'h0,
    KIND_LOCAL_LIST = 4'h1,
    KIND_TASK_AVL16 = 4'h2,
    KIND_TASK_AVL32 = 4'h3,
    KIND_TASK_BUSY16 = 4'h4,
    KIND_TASK_BUSY32 = 4'h5,
    KIND_CALL16 = 4'h6,
    KIND_CALL32 = 4'h7,
    KIND_TASK_GATE = 4'h8,
    KIND_INT16 = 4'h9,
    KIND_INT32 = 4'hA,
    KIND_TRAP16 = 4'hB,
    KIND_TRAP32 = 4'hC,
    KIND_CODE = 4'hD,
    KIND_DATA = 4'hE
  } sgdd_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_RESTORE = 3'b100
  } sgdd_state_e;

  typedef struct packed {
    logic [1:0] table_src;
    logic priv_raise;
    logic long_mode;
  } sgdd_ctrl_s;

  typedef struct packed {
    sgdd_kind_e kind;
    logic fault;
    logic [15:0] target_sel;
    logic [31:0] target_ofs;
    logic [4:0] param_cnt;
    logic [2:0] param_bytes;
    logic stack_switch;
    logic mode64;
    logic op32;
    logic addr64;
    logic base_zero;
    logic limit_skip;
    logic canon_chk;
  } sgdd_result_s;

endpackage : sgdd_pkg

// ---- hw/sgdd_state_mem.sv ----
`timescale 1ns/1ps
`include "sgdd_defs.svh"
module sgdd_state_mem (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Access port
  input wire logic wr_en_in,
  input wire logic [1:0] addr_in,
  input wire logic [31:0] wr_data_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] mem [`SGDD_STATE_WORDS];

  // Cleared at reset so a restart before any suspend restores zeros
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `SGDD_STATE_WORDS; i++) begin
        mem[i] <= `SGDD_RST_WORD;
      end
    end else if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= `SGDD_RST_WORD;
    end else begin
      rd_data_out <= mem[addr_in];
    end
  end
endmodule : sgdd_state_mem

// ---- hw/sgdd_top.sv ----
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sgdd_defs.svh"
// Functional notes
// [RULE1] Class bit zero means system descriptor, classified by four-bit type.
// [RULE2] Types 0000, 1000, 1010, 1101 decode as reserved illegal.
// [RULE3] 0010 local list; 0001/1001 available, 0011/1011 busy task areas.
// [RULE4] Call, task, interrupt and trap gate codes; gates point at code.
// [RULE5] Compatibility mode uses the legacy system layout.
// [RULE6] Suspend saves processor state into the task area; restart restores.
// [RULE7] Software builds a task area and points the task register at it.
// [RULE8] Call gates accepted from global or local list only.
// [RULE9] Interrupt and trap gates accepted from the vector list only.
// [RULE10] Task gates accepted from any list, including the vector list.
// [RULE11] Entry offset is upper[31:16] over lower[15:0], loaded into pointer.
// [RULE12] Code selector lower[31:16] loaded on call, interrupt or trap transfer.
// [RULE13] Task gates carry a task-area selector in lower[31:16].
// [RULE14] Call gates carry a five-bit parameter count in upper[4:0].
// [RULE15] Stack switch with copying only for call gate to higher privilege.
// [RULE16] Parameters are 4 bytes for 32-bit gates, 2 for 16-bit.
// [RULE17] In long mode the long bit picks 64-bit or compatibility mode.
// [RULE18] Compatibility mode reads code descriptors exactly as legacy.
// [RULE19] Ignored fields still load into the hidden segment copy.
// [RULE20] Long bit is upper bit 21; reserved in legacy mode.
// [RULE21] Long bit set requires size bit clear; both set is reserved.
// [RULE22] 64-bit code: base zero, no limit checks, canonical check instead.
// [RULE23] Using a reserved type raises a protection fault, no load.
// [RULE24] Reserved ignored gate fields never change decode results.
module sgdd_top
  import sgdd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Control-transfer results
  output logic [15:0] code_sel_out,
  output logic [31:0] instruction_pointer_out,
  output logic [15:0] task_sel_out,
  output logic xfer_done_out,
  output logic gp_fault_out,
  output logic busy_out
);

  function automatic logic is_gate(input sgdd_kind_e k);
    return k inside {KIND_CALL16, KIND_CALL32, KIND_TASK_GATE, KIND_INT16,
                     KIND_INT32, KIND_TRAP16, KIND_TRAP32};
  endfunction : is_gate

  function automatic logic is_state_word(input logic [7:0] a);
    return a[7:4] == `SGDD_STATE_PAGE;
  endfunction : is_state_word

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  function automatic sgdd_result_s decode_desc(input logic [31:0] lo,
                                               input logic [31:0] hi,
                                               input sgdd_ctrl_s c);
    sgdd_result_s r;
    logic bad_tbl;
    r = '0;
    bad_tbl = 1'b0;
    if (hi[`SGDD_BIT_CLASS]) begin
      if (hi[11]) begin
        r.kind = KIND_CODE;
        r.op32 = hi[`SGDD_BIT_DSIZE]; // [RULE18]
        r.addr64 = 1'b0;
        // Outside long mode the long bit is reserved and never looked at
        if (c.long_mode && hi[`SGDD_BIT_LONG]) begin // [RULE17] [RULE20]
          r.mode64 = 1'b1;
          r.op32 = 1'b1;
          r.addr64 = 1'b1;
          r.base_zero = 1'b1; // [RULE22]
          r.limit_skip = 1'b1;
          r.canon_chk = 1'b1;
          r.fault = hi[`SGDD_BIT_DSIZE]; // [RULE21]
        end
      end else begin
        r.kind = KIND_DATA;
      end
    end else begin
      // Same legacy table whether or not long mode is on
      unique case (hi[11:8]) // [RULE1] [RULE5]
        `SGDD_T_LOCAL: r.kind = KIND_LOCAL_LIST; // [RULE3]
        `SGDD_T_TASK16_AVL: r.kind = KIND_TASK_AVL16;
        `SGDD_T_TASK32_AVL: r.kind = KIND_TASK_AVL32;
        `SGDD_T_TASK16_BUSY: r.kind = KIND_TASK_BUSY16;
        `SGDD_T_TASK32_BUSY: r.kind = KIND_TASK_BUSY32;
        `SGDD_T_CALL16: r.kind = KIND_CALL16; // [RULE4]
        `SGDD_T_CALL32: r.kind = KIND_CALL32;
        `SGDD_T_TASK_GATE: r.kind = KIND_TASK_GATE;
        `SGDD_T_INT16: r.kind = KIND_INT16;
        `SGDD_T_INT32: r.kind = KIND_INT32;
        `SGDD_T_TRAP16: r.kind = KIND_TRAP16;
        `SGDD_T_TRAP32: r.kind = KIND_TRAP32;
        default: r.kind = KIND_ILLEGAL; // [RULE2]
      endcase
    end
    if (r.kind inside {KIND_CALL16, KIND_CALL32}) begin
      bad_tbl = c.table_src != `SGDD_TBL_GLOBAL && c.table_src != `SGDD_TBL_LOCAL; // [RULE8]
      r.param_cnt = hi[4:0]; // [RULE14]
      r.param_bytes = (r.kind == KIND_CALL32) ? `SGDD_PBYTES_32 : `SGDD_PBYTES_16; // [RULE16]
      r.stack_switch = c.priv_raise; // [RULE15]
    end
    if (r.kind inside {KIND_INT16, KIND_INT32, KIND_TRAP16, KIND_TRAP32}) begin
      bad_tbl = c.table_src != `SGDD_TBL_VECTOR; // [RULE9]
    end
    if (r.kind == KIND_TASK_GATE) begin
      bad_tbl = c.table_src > `SGDD_TBL_VECTOR; // [RULE10]
    end
    // Only named fields are picked; upper[7:5] and other ignored bits never enter
    if (is_gate(r.kind)) begin // [RULE24]
      r.target_sel = lo[31:16]; // [RULE12] [RULE13]
      if (r.kind != KIND_TASK_GATE) begin
        r.target_ofs = {hi[31:16], lo[15:0]}; // [RULE11]
      end
    end
    r.fault = r.fault | bad_tbl | (r.kind == KIND_ILLEGAL); // [RULE23]
    if (r.fault) begin
      r.target_sel = 16'h0000;
      r.target_ofs = 32'h0000_0000;
      r.stack_switch = 1'b0;
    end
    return r;
  endfunction : decode_desc

  // Bus slave state
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_ok;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [31:0] rd_mux;
  logic rd_ok;

  // Block state
  logic [31:0] desc_lo;
  logic [31:0] desc_hi;
  sgdd_ctrl_s ctrl;
  logic [31:0] live_state [`SGDD_STATE_WORDS];
  sgdd_result_s res;
  sgdd_result_s dec;
  logic res_valid;
  logic [31:0] hidden_lo;
  logic [31:0] hidden_hi;
  sgdd_state_e state;
  logic [2:0] step;
  logic [2:0] step_m1;
  logic cmd_wr;
  logic use_go;
  logic suspend_go;
  logic restart_go;
  logic [31:0] mem_rdata;

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
  assign wa = {aw_addr[7:2], 2'b00};
  assign ra = {s_axi_araddr_in[7:2], 2'b00};
  assign wr_ok = wa inside {`SGDD_OFS_DESC_LO, `SGDD_OFS_DESC_HI, `SGDD_OFS_CTRL,
                            `SGDD_OFS_CMD} || is_state_word(wa);
  assign dec = decode_desc(desc_lo, desc_hi, ctrl);
  assign cmd_wr = wr_go && wa == `SGDD_OFS_CMD && w_strb[0];
  assign use_go = cmd_wr && w_data[`SGDD_CMD_USE];
  assign suspend_go = cmd_wr && w_data[`SGDD_CMD_SUSPEND] && state == ST_IDLE;
  // Suspend outranks restart when both bits are written together
  assign restart_go = cmd_wr && w_data[`SGDD_CMD_RESTART] && !w_data[`SGDD_CMD_SUSPEND] &&
                      state == ST_IDLE;
  assign step_m1 = step - 3'h1;
  assign busy_out = state != ST_IDLE;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= `SGDD_RST_WORD;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SGDD_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_ok ? `SGDD_RESP_OKAY : `SGDD_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = `SGDD_RST_WORD;
    rd_ok = 1'b1;
    if (is_state_word(ra)) begin
      rd_mux = live_state[ra[3:2]];
    end else begin
      case (ra)
        `SGDD_OFS_DESC_LO: rd_mux = desc_lo;
        `SGDD_OFS_DESC_HI: rd_mux = desc_hi;
        `SGDD_OFS_CTRL: rd_mux = {28'h0, ctrl};
        `SGDD_OFS_CMD: rd_mux = `SGDD_RST_WORD;
        `SGDD_OFS_STATUS: rd_mux = {25'h0, res_valid, busy_out, res.fault, res.kind};
        `SGDD_OFS_TARGET_SEL: rd_mux = {16'h0, res.target_sel};
        `SGDD_OFS_TARGET_OFS: rd_mux = res.target_ofs;
        `SGDD_OFS_PARAM: rd_mux = {15'h0, res.stack_switch, 5'h0, res.param_bytes,
                                   3'h0, res.param_cnt};
        `SGDD_OFS_CODE_ATTR: rd_mux = {26'h0, res.canon_chk, res.limit_skip, res.base_zero,
                                       res.addr64, res.op32, res.mode64};
        `SGDD_OFS_HIDDEN_LO: rd_mux = hidden_lo;
        `SGDD_OFS_HIDDEN_HI: rd_mux = hidden_hi;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= `SGDD_RST_WORD;
      s_axi_rresp_out <= `SGDD_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_mux;
      s_axi_rresp_out <= rd_ok ? `SGDD_RESP_OKAY : `SGDD_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      desc_lo <= `SGDD_RST_WORD;
      desc_hi <= `SGDD_RST_WORD;
      ctrl <= '0;
    end else if (wr_go) begin
      if (wa == `SGDD_OFS_DESC_LO) begin
        desc_lo <= apply_strb(desc_lo, w_data, w_strb);
      end
      if (wa == `SGDD_OFS_DESC_HI) begin
        desc_hi <= apply_strb(desc_hi, w_data, w_strb);
      end
      if (wa == `SGDD_OFS_CTRL && w_strb[0]) begin
        ctrl <= w_data[3:0];
      end
    end
  end

  // Software writes to the state words are dropped while a save or restore runs
  for (genvar g = 0; g < `SGDD_STATE_WORDS; g++) begin : g_live
    always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
        live_state[g] <= `SGDD_RST_WORD;
      end else if (state == ST_RESTORE && step != 3'h0 && step_m1[1:0] == g) begin
        live_state[g] <= mem_rdata; // [RULE6]
      end else if (wr_go && state == ST_IDLE && is_state_word(wa) && wa[3:2] == g) begin
        live_state[g] <= apply_strb(live_state[g], w_data, w_strb);
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      step <= 3'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          step <= 3'h0;
          if (suspend_go) begin
            state <= ST_SAVE; // [RULE6]
          end else if (restart_go) begin
            state <= ST_RESTORE;
          end
        end
        ST_SAVE: begin
          step <= step + 3'h1;
          if (step == `SGDD_STATE_LAST) begin
            state <= ST_IDLE;
          end
        end
        ST_RESTORE: begin
          // One extra step because the memory read data arrive a cycle late
          step <= step + 3'h1;
          if (step == `SGDD_STATE_LAST + 3'h1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  sgdd_state_mem u_state_mem (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_en_in(state == ST_SAVE),
    .addr_in(step[1:0]),
    .wr_data_in(live_state[step[1:0]]),
    .rd_data_out(mem_rdata)
  );

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      res <= '0;
      res_valid <= 1'b0;
      xfer_done_out <= 1'b0;
      gp_fault_out <= 1'b0;
    end else begin
      xfer_done_out <= use_go && !dec.fault && is_gate(dec.kind);
      gp_fault_out <= use_go && dec.fault; // [RULE23]
      if (use_go) begin
        res <= dec;
        res_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      code_sel_out <= 16'h0000;
      instruction_pointer_out <= `SGDD_RST_WORD;
      task_sel_out <= 16'h0000;
      hidden_lo <= `SGDD_RST_WORD;
      hidden_hi <= `SGDD_RST_WORD;
    end else if (use_go && !dec.fault) begin
      if (is_gate(dec.kind) && dec.kind != KIND_TASK_GATE) begin
        code_sel_out <= dec.target_sel; // [RULE12]
        instruction_pointer_out <= dec.target_ofs; // [RULE11]
      end
      if (dec.kind == KIND_TASK_GATE) begin
        task_sel_out <= dec.target_sel; // [RULE13]
      end
      if (dec.kind == KIND_CODE) begin
        hidden_lo <= desc_lo; // [RULE19]
        hidden_hi <= desc_hi;
      end
    end
  end

  default clocking d_clk @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_illegal_fault;
    use_go && !desc_hi[12] && desc_hi[11:8] inside {4'h0, 4'h8, 4'hA, 4'hD}
      |=> res.fault && gp_fault_out && !xfer_done_out;
  endproperty
  a_illegal_fault: assert property (p_illegal_fault) // [RULE2]
    else $error("Reserved system type not faulted");

  property p_local_kind;
    use_go && !desc_hi[12] && desc_hi[11:8] == 4'h2 |=> res.kind == KIND_LOCAL_LIST;
  endproperty
  a_local_kind: assert property (p_local_kind) // [RULE3]
    else $error("Local list type misdecoded");

  property p_offset;
    use_go && !desc_hi[12] && desc_hi[11:8] == 4'hC && ctrl.table_src == 2'h0
      |=> instruction_pointer_out == {$past(desc_hi[31:16]), $past(desc_lo[15:0])}
          && code_sel_out == $past(desc_lo[31:16]) && xfer_done_out;
  endproperty
  a_offset: assert property (p_offset) // [RULE11]
    else $error("Call gate target not loaded");

  property p_vector_only;
    use_go && !desc_hi[12] && desc_hi[11:8] inside {4'h6, 4'h7, 4'hE, 4'hF}
      && ctrl.table_src != 2'h2 |=> gp_fault_out;
  endproperty
  a_vector_only: assert property (p_vector_only) // [RULE9]
    else $error("Interrupt gate outside vector list accepted");

  property p_pbytes;
    res.kind == KIND_CALL32 |-> res.param_bytes == 3'h4;
  endproperty
  a_pbytes: assert property (p_pbytes) // [RULE16]
    else $error("32-bit call gate parameter size wrong");

  property p_stack_switch;
    res.stack_switch |-> res.kind inside {KIND_CALL16, KIND_CALL32} && !res.fault;
  endproperty
  a_stack_switch: assert property (p_stack_switch) // [RULE15]
    else $error("Stack switch outside call gate");

  property p_long_reserved;
    use_go && desc_hi[12] && desc_hi[11] && ctrl.long_mode && desc_hi[21] && desc_hi[22]
      |=> gp_fault_out ##0 res.mode64;
  endproperty
  a_long_reserved: assert property (p_long_reserved) // [RULE21]
    else $error("Long code with size bit set not faulted");

  property p_mode64_attrs;
    res.mode64 |-> res.base_zero && res.limit_skip && res.canon_chk && res.addr64;
  endproperty
  a_mode64_attrs: assert property (p_mode64_attrs) // [RULE22]
    else $error("64-bit code attributes incomplete");

  property p_legacy_long_bit;
    use_go && desc_hi[12] && desc_hi[11] && !ctrl.long_mode |=> !res.mode64;
  endproperty
  a_legacy_long_bit: assert property (p_legacy_long_bit) // [RULE20]
    else $error("Long bit honoured in legacy mode");

  property p_save_len;
    $rose(state == ST_SAVE) |-> (state == ST_SAVE) [*4] ##1 state == ST_IDLE;
  endproperty
  a_save_len: assert property (p_save_len) // [RULE6]
    else $error("Save did not take four cycles");

  c_save: cover property (state == ST_SAVE ##4 state == ST_IDLE);
  c_restore: cover property (state == ST_RESTORE ##5 state == ST_IDLE);
  c_stack: cover property (use_go ##1 res.stack_switch);
  c_fault: cover property (gp_fault_out);

endmodule : sgdd_top

// ---- sim/sgdd_sw_tables.sv ----
`timescale 1ns/1ps
module sgdd_sw_tables (
  // Entry select
  input wire logic [3:0] type_in,
  // Descriptor words
  output logic [31:0] lo_out,
  output logic [31:0] hi_out
);
  // Reserved fields carry junk so that the decode must ignore them
  assign hi_out = {16'hC0DE, 4'hE, type_in, 3'h5, 5'h13};
  assign lo_out = {16'h0018, 16'h4321};
endmodule : sgdd_sw_tables

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, xfer, gp, busy;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, ip, rdv, d_lo, d_hi;
  logic [15:0] csel, tsel;
  logic [3:0] ptype = 4'h0;
  logic got_gp, got_xfer;
  int errors = 0;
  int n_compared = 0;
  // Columns: fault, table source, type, kind (F = kind not compared)
  logic [15:0] rows [0:20] = '{16'h1000, 16'h0012, 16'h0021, 16'h0034, 16'h0046,
    16'h0258, 16'h0269, 16'h027B, 16'h1080, 16'h0093, 16'h10A0, 16'h00B5, 16'h00C7,
    16'h10D0, 16'h02EA, 16'h02FC, 16'h12CF, 16'h10EF, 16'h135F, 16'h0146, 16'h0058};

  sgdd_top u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .code_sel_out(csel),
    .instruction_pointer_out(ip), .task_sel_out(tsel), .xfer_done_out(xfer),
    .gp_fault_out(gp), .busy_out(busy));
  sgdd_sw_tables u_tables (.type_in(ptype), .lo_out(d_lo), .hi_out(d_hi));

  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic fail(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) fail(m);
  endtask : chk

  task automatic wrap_up;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    if (bvalid !== 1'b1) begin
      fail("write timeout");
      wrap_up();
    end
    resp = bresp;
    got_gp = gp;
    got_xfer = xfer;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (rvalid !== 1'b1) begin
      fail("read timeout");
      wrap_up();
    end
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic use_desc(input logic [31:0] lo, input logic [31:0] hi, input logic [3:0] c);
    axi_wr(8'h00, lo);
    axi_wr(8'h04, hi);
    axi_wr(8'h08, {28'h0, c});
    axi_wr(8'h0C, 32'h1);
  endtask : use_desc

  task automatic pick(input logic [3:0] t);
    ptype = t;
    @(negedge core_clk_in);
  endtask : pick

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge core_clk_in);
      n++;
    end
    chk(busy === 1'b0, "busy stuck");
    if (busy !== 1'b0) wrap_up();
  endtask : wait_idle

  initial begin
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk(awready === 1'b1 && arready === 1'b1 && bvalid === 1'b0 && busy === 1'b0, "reset");
    axi_rd(8'h08);
    chk(rdv === 32'h0, "ctrl reset value");
    for (int i = 0; i < 21; i++) begin
      pick(rows[i][7:4]);
      use_desc(d_lo, d_hi, {rows[i][9:8], 2'b10});
      chk(got_gp === rows[i][12], "fault pulse");
      axi_rd(8'h10);
      chk(rdv[4] === rows[i][12], "status fault");
      if (rows[i][3:0] != 4'hF) begin
        chk(rdv[3:0] === rows[i][3:0], "kind");
      end
    end
    pick(4'hC);
    use_desc(d_lo, d_hi, 4'h2);
    chk(got_xfer === 1'b1 && csel === 16'h0018, "code selector");
    chk(ip === 32'hC0DE_4321, "entry offset");
    axi_rd(8'h1C);
    chk(rdv === 32'h0001_0413, "param 32");
    pick(4'h4);
    use_desc(d_lo, d_hi, 4'h0);
    axi_rd(8'h1C);
    chk(rdv === 32'h0000_0213, "param 16");
    pick(4'h5);
    use_desc(d_lo, d_hi, 4'h8);
    chk(tsel === 16'h0018, "task selector");
    pick(4'h2);
    use_desc(d_lo, d_hi, 4'h1);
    axi_rd(8'h10);
    chk(rdv[4:0] === 5'h01, "compat list");
    use_desc(32'h1234_5678, 32'h0020_9B00, 4'h1);
    axi_rd(8'h20);
    chk(rdv === 32'h0000_003F, "64-bit attrs");
    axi_rd(8'h28);
    chk(rdv === 32'h0020_9B00, "hidden copy");
    use_desc(32'h0, 32'h0000_9B00, 4'h1);
    axi_rd(8'h20);
    chk(rdv[0] === 1'b0, "compat code");
    use_desc(32'h0, 32'h0060_9B00, 4'h1);
    chk(got_gp === 1'b1, "long with size");
    // Outside long mode the long bit must not select 64-bit code
    use_desc(32'h0, 32'h0020_9B00, 4'h0);
    axi_rd(8'h20);
    chk(rdv === 32'h0000_0000, "legacy long bit");
    use_desc(32'h0, 32'h0000_9300, 4'h0);
    axi_rd(8'h10);
    chk(rdv[4:0] === 5'h0E, "data not system");
    axi_rd(8'h30);
    chk(resp === 2'h2, "unmapped read");
    axi_wr(8'h10, 32'h1);
    chk(resp === 2'h2, "read-only write");
    // Software fills the live state before relying on a task switch
    axi_wr(8'h40, 32'hA5A5_0001);
    axi_wr(8'h0C, 32'h2);
    chk(busy === 1'b1, "save busy");
    wait_idle();
    axi_wr(8'h40, 32'h0);
    axi_wr(8'h0C, 32'h4);
    wait_idle();
    axi_rd(8'h40);
    chk(rdv === 32'hA5A5_0001, "restored state");
    // A reset in mid-run must drop loaded targets and the live state
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    chk(csel === 16'h0 && ip === 32'h0 && tsel === 16'h0 && busy === 1'b0, "mid-run reset");
    axi_rd(8'h40);
    chk(rdv === 32'h0, "state after reset");
    wrap_up();
  end
endmodule : tb
